// File: core/dd_justify.sv
// Aligns the 12-bit converter word out of a high and a low data byte
`timescale 1ns/1ps
`default_nettype none
module dd_justify (
   input  wire logic [7:0]  data_high_i,
   input  wire logic [7:0]  data_low_i,
   input  wire logic [2:0]  justify_select_i,
   output logic      [11:0] word_o
);

   // Bits outside the chosen alignment never reach the word
   always_comb begin
      if (justify_select_i[2]) begin
         word_o = {data_high_i[7:0], data_low_i[7:4]};
      end else begin
         case (justify_select_i)
            dd_pkg::JUST_NIBBLE: word_o = {data_high_i[3:0], data_low_i[7:0]};
            dd_pkg::JUST_FIVE:   word_o = {data_high_i[4:0], data_low_i[7:1]};
            dd_pkg::JUST_SIX:    word_o = {data_high_i[5:0], data_low_i[7:2]};
            dd_pkg::JUST_SEVEN:  word_o = {data_high_i[6:0], data_low_i[7:3]};
            default:             word_o = {data_high_i[7:0], data_low_i[7:4]};
         endcase
      end
   end

endmodule // dd_justify
`default_nettype wire

// File: core/dd_pkg.sv
// Constants and types shared by the dual converter update and justify block
package dd_pkg;

   localparam int unsigned DATA_W = 8;
   localparam int unsigned WORD_W = 12;
   localparam int unsigned NUM_CH = 2;

   // Byte addresses of the register bus
   localparam logic [7:0] ADDR_DATA_LOW  = 8'hd2;
   localparam logic [7:0] ADDR_DATA_HIGH = 8'hd3;
   localparam logic [7:0] ADDR_CONTROL   = 8'hd4;

   // Register page that selects each channel
   localparam logic [7:0] PAGE_CH0 = 8'h00;
   localparam logic [7:0] PAGE_CH1 = 8'h01;

   // Control field positions
   localparam int unsigned CTRL_ENABLE_BIT = 7;
   localparam int unsigned CTRL_TRIG_MSB   = 4;
   localparam int unsigned CTRL_TRIG_LSB   = 3;
   localparam int unsigned CTRL_JUST_MSB   = 2;
   localparam int unsigned CTRL_JUST_LSB   = 0;

   // Bits 6 and 5 are unused: never stored, read as zero
   localparam logic [7:0] CTRL_WRITE_MASK = 8'h9f;

   // Values after reset
   localparam logic [7:0]  RST_DATA_LOW  = 8'h00;
   localparam logic [7:0]  RST_DATA_HIGH = 8'h00;
   localparam logic [7:0]  RST_CONTROL   = 8'h00;
   localparam logic [11:0] RST_WORD      = 12'h000;
   localparam logic [7:0]  RST_RDATA     = 8'h00;

   // Update trigger select, in field order
   typedef enum logic [1:0] {
      TRIG_HIGH_WRITE,
      TRIG_TIMER3,
      TRIG_TIMER4,
      TRIG_TIMER2
   } dd_trig_e;

   // Justification select values
   localparam logic [2:0] JUST_NIBBLE = 3'h0;
   localparam logic [2:0] JUST_FIVE   = 3'h1;
   localparam logic [2:0] JUST_SIX    = 3'h2;
   localparam logic [2:0] JUST_SEVEN  = 3'h3;

   // Whole state of the top module
   typedef struct packed {
      logic [NUM_CH-1:0][DATA_W-1:0] data_low;
      logic [NUM_CH-1:0][DATA_W-1:0] data_high;
      logic [NUM_CH-1:0][DATA_W-1:0] control;
      logic [NUM_CH-1:0][WORD_W-1:0] word;
      logic [DATA_W-1:0]             rdata;
      logic                          rhit;
   } dd_state_s;

endpackage : dd_pkg

// File: core/dd_trigger.sv
// Picks the event that moves a channel's data into its converter latch
`timescale 1ns/1ps
`default_nettype none
module dd_trigger (
   input  wire logic [1:0] update_trigger_i,
   input  wire logic       high_write_i,
   input  wire logic       timer2_ovf_i,
   input  wire logic       timer3_ovf_i,
   input  wire logic       timer4_ovf_i,
   output logic            update_o
);

   // Overflows are one-cycle pulses, so each gives exactly one update
   always_comb begin
      case (dd_pkg::dd_trig_e'(update_trigger_i))
         dd_pkg::TRIG_HIGH_WRITE: update_o = high_write_i;
         dd_pkg::TRIG_TIMER3:     update_o = timer3_ovf_i;
         dd_pkg::TRIG_TIMER4:     update_o = timer4_ovf_i;
         dd_pkg::TRIG_TIMER2:     update_o = timer2_ovf_i;
         default:                 update_o = 1'b0;
      endcase
   end

endmodule // dd_trigger
`default_nettype wire

// File: core/dd_update_top.sv
// Register file, paging and update latches of the two 12-bit converter channels
//
// Summary of operation
// - Control bit 7 clear shuts a channel down with its output inactive.
// - Control bits 6 and 5 read as zero; writes to them are ignored.
// - Trigger select is control bits 4..3; justification select is bits 2..0.
// - Trigger 00 latches the converter word when the high byte is written.
// - Triggers 01, 10, 11 latch on timer 3, timer 4, timer 2 overflow.
// - In timer modes data writes are held until the chosen overflow arrives.
// - Low byte alone never changes output in write mode; write low then high.
// - Select 000 takes high bits 3..0 and the whole low byte.
// - Select 001 takes high bits 4..0 and low bits 7..1.
// - Select 010 takes high bits 5..0 and low bits 7..2.
// - Select 011 takes high bits 6..0 and low bits 7..3.
// - Select 1xx takes the whole high byte and low bits 7..4.
// - Second channel uses the same addresses, chosen by register page 1.
// - Second channel has its own enable, trigger and justification, identical.
// - Reset clears low byte and control of each channel to zero.
`timescale 1ns/1ps
`default_nettype none
module dd_update_top (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // Byte-wide paged register bus
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic [7:0]  sfr_page_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   input  wire logic [7:0]  sfr_wdata_i,
   output logic      [7:0]  sfr_rdata_o,
   output logic             sfr_rhit_o,
   // Timer overflow pulses, same clock
   input  wire logic        timer2_ovf_i,
   input  wire logic        timer3_ovf_i,
   input  wire logic        timer4_ovf_i,
   // Converter side
   output logic      [11:0] ch0_word_o,
   output logic      [11:0] ch1_word_o,
   output logic             ch0_enable_o,
   output logic             ch1_enable_o
);

   localparam int unsigned NCH = dd_pkg::NUM_CH;

   dd_pkg::dd_state_s state_q;
   dd_pkg::dd_state_s state_d;

   ////////////////////////////////////////////////////////////////////////////
   // Address and page decode

   logic [NCH-1:0] ch_sel;
   logic           addr_low;
   logic           addr_high;
   logic           addr_ctrl;
   logic           addr_any;

   // Same three addresses serve both channels; the page picks one
   assign ch_sel[0] = (sfr_page_i == dd_pkg::PAGE_CH0);
   assign ch_sel[1] = (sfr_page_i == dd_pkg::PAGE_CH1);
   assign addr_low  = (sfr_addr_i == dd_pkg::ADDR_DATA_LOW);
   assign addr_high = (sfr_addr_i == dd_pkg::ADDR_DATA_HIGH);
   assign addr_ctrl = (sfr_addr_i == dd_pkg::ADDR_CONTROL);
   assign addr_any  = addr_low | addr_high | addr_ctrl;

   ////////////////////////////////////////////////////////////////////////////
   // Per channel: register write, trigger and justification

   logic [NCH-1:0][7:0]  low_nx;
   logic [NCH-1:0][7:0]  high_nx;
   logic [NCH-1:0][7:0]  ctrl_nx;
   logic [NCH-1:0][11:0] word_nx;
   logic [NCH-1:0]       high_wr;
   logic [NCH-1:0]       update;

   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_ch
         logic low_wr;
         logic ctrl_wr;

         assign low_wr      = sfr_wr_i & ch_sel[ch] & addr_low;
         assign high_wr[ch] = sfr_wr_i & ch_sel[ch] & addr_high;
         assign ctrl_wr     = sfr_wr_i & ch_sel[ch] & addr_ctrl;

         // Data bytes only store; they reach the converter through the latch
         assign low_nx[ch]  = low_wr      ? sfr_wdata_i : state_q.data_low[ch];
         assign high_nx[ch] = high_wr[ch] ? sfr_wdata_i : state_q.data_high[ch];
         // Unused control bits are dropped on the way
         assign ctrl_nx[ch] = ctrl_wr ? (sfr_wdata_i & dd_pkg::CTRL_WRITE_MASK)
                                      : state_q.control[ch];

         // Current trigger select steers the update source
         dd_trigger u_trigger (
            .update_trigger_i (state_q.control[ch][dd_pkg::CTRL_TRIG_MSB:dd_pkg::CTRL_TRIG_LSB]),
            .high_write_i     (high_wr[ch]),
            .timer2_ovf_i     (timer2_ovf_i),
            .timer3_ovf_i     (timer3_ovf_i),
            .timer4_ovf_i     (timer4_ovf_i),
            .update_o         (update[ch])
         );

         // Word formed from the bytes as they stand after this cycle's write,
         // so a high-byte write is latched together with its own value
         dd_justify u_justify (
            .data_high_i      (high_nx[ch]),
            .data_low_i       (low_nx[ch]),
            .justify_select_i (state_q.control[ch][dd_pkg::CTRL_JUST_MSB:dd_pkg::CTRL_JUST_LSB]),
            .word_o           (word_nx[ch])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read mux

   logic [7:0] rd_value;
   logic       rd_hit;

   always_comb begin
      rd_value = 8'h00;
      rd_hit   = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         if (ch_sel[i] && addr_any) begin
            rd_hit = 1'b1;
            if (addr_low) begin
               rd_value = state_q.data_low[i];
            end else if (addr_high) begin
               rd_value = state_q.data_high[i];
            end else begin
               // Stored bits 6..5 are always zero
               rd_value = state_q.control[i] & dd_pkg::CTRL_WRITE_MASK;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      state_d = state_q;
      for (int i = 0; i < NCH; i++) begin
         state_d.data_low[i]  = low_nx[i];
         state_d.data_high[i] = high_nx[i];
         state_d.control[i]   = ctrl_nx[i];
         // Only the chosen event moves held data to the converter
         if (update[i]) begin
            state_d.word[i] = word_nx[i];
         end
      end
      // Answer registered one cycle after the strobe; unmapped reads give zero
      if (sfr_rd_i) begin
         state_d.rdata = rd_value;
         state_d.rhit  = rd_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < NCH; i++) begin
            state_q.data_low[i]  <= dd_pkg::RST_DATA_LOW;
            state_q.data_high[i] <= dd_pkg::RST_DATA_HIGH;
            state_q.control[i]   <= dd_pkg::RST_CONTROL;
            state_q.word[i]      <= dd_pkg::RST_WORD;
         end
         state_q.rdata <= dd_pkg::RST_RDATA;
         state_q.rhit  <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register

   assign sfr_rdata_o  = state_q.rdata;
   assign sfr_rhit_o   = state_q.rhit;
   assign ch0_word_o   = state_q.word[0];
   assign ch1_word_o   = state_q.word[1];
   // Enable low means the analog channel is shut down, pin inactive
   assign ch0_enable_o = state_q.control[0][dd_pkg::CTRL_ENABLE_BIT];
   assign ch1_enable_o = state_q.control[1][dd_pkg::CTRL_ENABLE_BIT];

endmodule // dd_update_top
`default_nettype wire

// File: verif/dd_update_properties.sv
// Port-level assertions of the converter update block
`timescale 1ns/1ps
`default_nettype none
module dd_update_properties (
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic [7:0]  sfr_addr_i,
   input wire logic [7:0]  sfr_page_i,
   input wire logic        sfr_wr_i,
   input wire logic        sfr_rd_i,
   input wire logic [7:0]  sfr_wdata_i,
   input wire logic [7:0]  sfr_rdata_o,
   input wire logic        sfr_rhit_o,
   input wire logic        timer2_ovf_i,
   input wire logic        timer3_ovf_i,
   input wire logic        timer4_ovf_i,
   input wire logic [11:0] ch0_word_o,
   input wire logic [11:0] ch1_word_o,
   input wire logic        ch0_enable_o,
   input wire logic        ch1_enable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [7:0] c0_q, c1_q;
   wire p0 = sfr_page_i == 8'h00;
   wire p1 = sfr_page_i == 8'h01;
   wire wc = sfr_wr_i && sfr_addr_i == dd_pkg::ADDR_CONTROL;
   wire hw = sfr_wr_i && sfr_addr_i == dd_pkg::ADDR_DATA_HIGH;
   // Shadow of the trigger fields, value before the edge
   function automatic logic sel(logic [1:0] m, logic h);
      return m == 2'h0 ? h : m == 2'h1 ? timer3_ovf_i : m == 2'h2 ? timer4_ovf_i : timer2_ovf_i;
   endfunction
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         c0_q <= 8'h00;
         c1_q <= 8'h00;
      end else begin
         if (wc && p0) c0_q <= sfr_wdata_i;
         if (wc && p1) c1_q <= sfr_wdata_i;
      end
   end
   property p_en0; wc && p0 |=> ch0_enable_o == $past(sfr_wdata_i[7]); endproperty
   a_en0: assert property (p_en0) else $error("ch0 enable wrong");
   property p_en1; wc && p1 |=> ch1_enable_o == $past(sfr_wdata_i[7]); endproperty
   a_en1: assert property (p_en1) else $error("ch1 enable wrong");
   property p_enh; !(wc && p0) |=> $stable(ch0_enable_o); endproperty
   a_enh: assert property (p_enh) else $error("ch0 enable moved");
   property p_rsv; sfr_rd_i && sfr_addr_i == dd_pkg::ADDR_CONTROL |=> sfr_rdata_o[6:5] == 2'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("unused bits not zero");
   property p_map; sfr_rd_i && (p0 || p1) && sfr_addr_i inside {8'hd2, 8'hd3, 8'hd4} |=> sfr_rhit_o; endproperty
   a_map: assert property (p_map) else $error("mapped read missed");
   property p_unm; sfr_rd_i && !(p0 || p1) |=> !sfr_rhit_o && sfr_rdata_o == 8'h00; endproperty
   a_unm: assert property (p_unm) else $error("unmapped page answered");
   property p_w0; !sel(c0_q[4:3], hw && p0) |=> $stable(ch0_word_o); endproperty
   a_w0: assert property (p_w0) else $error("ch0 word moved untriggered");
   property p_w1; !sel(c1_q[4:3], hw && p1) |=> $stable(ch1_word_o); endproperty
   a_w1: assert property (p_w1) else $error("ch1 word moved untriggered");
endmodule // dd_update_properties
bind dd_update_top dd_update_properties dd_update_properties_inst (.clk_i, .sys_rst_i, .sfr_addr_i,
   .sfr_page_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_rhit_o, .timer2_ovf_i,
   .timer3_ovf_i, .timer4_ovf_i, .ch0_word_o, .ch1_word_o, .ch0_enable_o, .ch1_enable_o);
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench of the converter update block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [7:0]  addr = 8'h00, page = 8'h00, wdata = 8'h00, rdata;
   logic        wr = 1'b0, rd = 1'b0, rhit, en0, en1;
   logic [2:0]  tmr = 3'h0;
   logic [11:0] w0, w1;
   logic [11:0] mw [2] = '{12'h000, 12'h000};
   logic [31:0] seed = 32'hed3e;
   int          error_cnt = 0, check_count = 0;
   dd_update_top dd_update_top_inst (.clk_i, .sys_rst_i, .sfr_addr_i(addr), .sfr_page_i(page),
      .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sfr_rhit_o(rhit),
      .timer2_ovf_i(tmr[0]), .timer3_ovf_i(tmr[1]), .timer4_ovf_i(tmr[2]), .ch0_word_o(w0),
      .ch1_word_o(w1), .ch0_enable_o(en0), .ch1_enable_o(en1));
   always #5 clk_i = ~clk_i;
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [11:0] just(logic [7:0] h, logic [7:0] l, logic [2:0] f);
      case (f)
         3'h0: return {h[3:0], l};
         3'h1: return {h[4:0], l[7:1]};
         3'h2: return {h[5:0], l[7:2]};
         3'h3: return {h[6:0], l[7:3]};
         default: return {h, l[7:4]};
      endcase
   endfunction
   task automatic fail(string m);
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask
   task automatic chk_word(logic [11:0] g, logic [11:0] e);
      check_count++;
      if (g !== e) fail($sformatf("word %h exp %h", g, e));
   endtask
   task automatic chk_bit(logic g, logic e);
      check_count++;
      if (g !== e) fail("enable flag");
   endtask
   // Strobes always last one cycle, then one idle cycle
   task automatic bus(logic w, logic [7:0] p, logic [7:0] a, logic [7:0] d);
      @(posedge clk_i);
      #1;
      {wr, rd, page, addr, wdata} = {w, !w, p, a, d};
      @(posedge clk_i);
      #1;
      {wr, rd} = 2'b00;
   endtask
   task automatic rd_chk(logic [7:0] p, logic [7:0] a, logic [7:0] e, logic h);
      bus(1'b0, p, a, 8'h00);
      check_count++;
      if (rdata !== e || rhit !== h) fail($sformatf("read %h exp %h", rdata, e));
   endtask
   task automatic pulse(logic [2:0] v);
      @(posedge clk_i);
      #1;
      tmr = v;
      @(posedge clk_i);
      #1;
      tmr = 3'h0;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      logic [7:0] c, h, l;
      logic [2:0] f;
      logic [1:0] m;
      repeat (3) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
      chk_word(w0 | w1, 12'h000);
      chk_bit(en0 | en1, 1'b0);
      for (c = 8'h00; c < 8'h02; c++) begin
         rd_chk(c, 8'hd2, 8'h00, 1'b1);
         rd_chk(c, 8'hd4, 8'h00, 1'b1);
         bus(1'b1, c, 8'hd4, 8'hff);
         rd_chk(c, 8'hd4, 8'h9f, 1'b1);
         chk_bit(c[0] ? en1 : en0, 1'b1);
      end
      bus(1'b1, 8'h02, 8'hd4, 8'h00);
      rd_chk(8'h02, 8'hd4, 8'h00, 1'b0);
      rd_chk(8'h00, 8'hd5, 8'h00, 1'b0);
      chk_bit(en0, 1'b1);
      $display("test registers done");
      for (int i = 0; i < 32; i++) begin
         seed = lfsr(seed);
         c = 8'(i & 1);
         f = 3'(i >> 1);
         {h, l} = i < 2 ? 16'hffff : seed[15:0];
         bus(1'b1, c, 8'hd4, {5'b10000, f});
         bus(1'b1, c, 8'hd2, l);
         chk_word(c[0] ? w1 : w0, mw[c[0]]);
         bus(1'b1, c, 8'hd3, h);
         mw[c[0]] = just(h, l, f);
         chk_word(c[0] ? w1 : w0, mw[c[0]]);
         chk_word(c[0] ? w0 : w1, mw[!c[0]]);
      end
      $display("test write mode done");
      for (int j = 0; j < 6; j++) begin
         seed = lfsr(seed);
         c = 8'(j & 1);
         m = 2'(j / 2 + 1);
         f = seed[18:16];
         {h, l} = seed[15:0];
         bus(1'b1, c, 8'hd4, {1'b1, 2'b00, m, f});
         bus(1'b1, c, 8'hd2, l);
         bus(1'b1, c, 8'hd3, h);
         chk_word(c[0] ? w1 : w0, mw[c[0]]);
         pulse(~(3'b001 << (m % 3)));
         chk_word(c[0] ? w1 : w0, mw[c[0]]);
         pulse(3'b001 << (m % 3));
         mw[c[0]] = just(h, l, f);
         chk_word(c[0] ? w1 : w0, mw[c[0]]);
      end
      $display("test timer mode done");
      bus(1'b1, 8'h00, 8'hd4, 8'h00);
      chk_bit(en0, 1'b0);
      $display("test shutdown done");
      end_of_test();
   end
   initial begin
      #50000;
      fail("watchdog expired");
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
